// *** design/pbt_pkg.sv ***
// Constants shared by the power button timer and top-level interrupt mask block.
`default_nettype none
package pbt_pkg;
    // Bus geometry.
    localparam int unsigned AW = 8;
    localparam int unsigned DW = 32;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_MASK     = 8'h13;
    localparam logic [7:0] IDX_CFG      = 8'h14;
    localparam logic [7:0] IDX_STAT     = 8'h15;
    localparam logic [7:0] IDX_EVT_STAT = 8'h20;
    localparam logic [7:0] IDX_EVT_CLR  = 8'h21;
    localparam logic [7:0] IDX_EVT_EN   = 8'h22;
    localparam logic [7:0] IDX_NONE     = 8'hff;

    // Group mask register layout.
    localparam logic [7:0] MASK_RESET    = 8'ha5;
    localparam logic [7:0] MASK_WR_BITS  = 8'ha5;
    localparam int unsigned RESET_CAUSE_BIT = 7;
    localparam int unsigned POWER_MON_BIT   = 5;
    localparam int unsigned POWER_SRC_BIT   = 2;
    localparam int unsigned BUTTON_BIT      = 0;

    // Button configuration layout.
    localparam logic [7:0] CFG_RESET     = 8'h1f;
    localparam int unsigned DEB_SEL_BIT  = 7;
    localparam int unsigned CLR_BIT      = 6;
    localparam int unsigned THR_W        = 6;
    localparam logic [5:0] HELD_MAX      = 6'h3f;

    // Button status reset value.
    localparam logic [7:0] STAT_RESET    = 8'h00;

    // Event status bits.
    localparam int unsigned EVT_W         = 3;
    localparam int unsigned EVT_PRESS     = 0;
    localparam int unsigned EVT_RELEASE   = 1;
    localparam int unsigned EVT_EMERGENCY = 2;

    // Timing.
    localparam int unsigned CLK_HZ       = 40_000_000;
    localparam int unsigned DEB_MS       = 30;
    localparam int unsigned SEC_S        = 1;
    localparam int unsigned DEB_CYCLES_DEF = CLK_HZ / 1000 * DEB_MS;
    localparam int unsigned SEC_CYCLES_DEF = CLK_HZ * SEC_S;
endpackage
`default_nettype wire

// *** design/pbt_top.sv ***
// Power button hold timer, top-level group interrupt masks and AXI4-Lite registers.
//
// Contract
// R1 - Mask bit 7 blocks reset-cause group
// R2 - Mask bit 5 blocks power-monitor group
// R3 - Mask bit 2 blocks power-source group
// R4 - Mask bit 0 blocks button group
// R5 - Mask resets to a5, reserved bits read-only
// R6 - Debounce 30 ms unless select bit set
// R7 - Clear bit resets hold timer, self-clears
// R8 - Six-bit threshold, 0 to 63 seconds
// R9 - Configuration resets to 1f
// R10 - Level bit 0 held, 1 released
// R11 - Six-bit held time in seconds, max 63
// R12 - Held time 0 and 1 mean disabled
// R13 - Button status read-only, resets to zero
// R14 - Counter counts seconds, saturates, restarts on release
// R15 - Emergency reset once per press at threshold
//
// The AXI4-Lite interface to the registers is this design's own decision.
`default_nettype none
module pbt_top #(
    parameter int unsigned DEB_CYCLES = pbt_pkg::DEB_CYCLES_DEF,
    parameter int unsigned SEC_CYCLES = pbt_pkg::SEC_CYCLES_DEF
) (
    // Clock and reset.
    input  wire logic                       core_clk,
    input  wire logic                       rstn,
    // AXI4-Lite write address and data.
    input  wire logic [pbt_pkg::AW-1:0]     s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [pbt_pkg::DW-1:0]     s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    // AXI4-Lite read.
    input  wire logic [pbt_pkg::AW-1:0]     s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [pbt_pkg::DW-1:0]          s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    // Button pin, low while pressed.
    input  wire logic                       button_pin_n,
    // First-level group requests and their masked outputs.
    input  wire logic                       reset_cause_req,
    input  wire logic                       power_monitor_req,
    input  wire logic                       power_source_req,
    input  wire logic                       button_req,
    output logic                            reset_cause_int,
    output logic                            power_monitor_int,
    output logic                            power_source_int,
    output logic                            button_int,
    // Emergency reset and block interrupt.
    output logic                            emergency_reset,
    output logic                            irq
);
    import pbt_pkg::*;

    // Maps a byte address to a register index, misaligned addresses to none.
    function automatic logic [7:0] reg_index(input logic [AW-1:0] addr);
        reg_index = (addr[1:0] == 2'h0) ? {2'h0, addr[AW-1:2]} : IDX_NONE;
    endfunction

    // True when an index names a register of this block.
    function automatic logic idx_mapped(input logic [7:0] idx);
        idx_mapped = (idx == IDX_MASK) || (idx == IDX_CFG) || (idx == IDX_STAT) ||
                     (idx == IDX_EVT_STAT) || (idx == IDX_EVT_CLR) || (idx == IDX_EVT_EN);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////
    // Declarations.
    logic              aw_ff, nxt_aw, w_ff, nxt_w;
    logic [AW-1:0]     awaddr_ff, nxt_awaddr;
    logic [DW-1:0]     wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
    logic              wstrb0_ff, nxt_wstrb0;
    logic              bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
    logic [1:0]        bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic              wr_fire, wr_en;
    logic [7:0]        wr_idx, rd_idx;
    logic [7:0]        mask_ff, nxt_mask;
    logic              deb_sel_ff, nxt_deb_sel;
    logic [THR_W-1:0]  thr_ff, nxt_thr;
    logic [EVT_W-1:0]  evt_stat_ff, nxt_evt_stat, evt_en_ff, nxt_evt_en, evt_set;
    logic [3:0]        grp_ff, nxt_grp;
    logic              clr_cmd;
    logic              btn_s1_ff, btn_s2_ff;
    logic [31:0]       deb_cnt_ff, nxt_deb_cnt, sec_cnt_ff, nxt_sec_cnt;
    logic              level_ff, nxt_level, armed_ff, nxt_armed;
    logic [5:0]        held_ff, nxt_held;
    logic              fired_ff, nxt_fired, emerg_ff, nxt_emerg;
    logic              held;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Bus slave. Address and data are latched separately and the write is done once both
    // are in, so the master may offer them in either order.
    assign s_axi_awready = !aw_ff && !bvalid_ff;
    assign s_axi_wready  = !w_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rresp   = rresp_ff;
    assign s_axi_rdata   = rdata_ff;
    assign wr_fire       = aw_ff && w_ff;
    assign wr_idx        = reg_index(awaddr_ff);
    assign rd_idx        = reg_index(s_axi_araddr);
    assign wr_en         = wr_fire && wstrb0_ff;

    // Next values of the bus channels and the read mux.
    always_comb begin
        nxt_aw     = aw_ff;
        nxt_awaddr = awaddr_ff;
        nxt_w      = w_ff;
        nxt_wdata  = wdata_ff;
        nxt_wstrb0 = wstrb0_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp  = bresp_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rresp  = rresp_ff;
        nxt_rdata  = rdata_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw     = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w      = 1'b1;
            nxt_wdata  = s_axi_wdata;
            nxt_wstrb0 = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            nxt_aw     = 1'b0;
            nxt_w      = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp  = idx_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = idx_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
            // Narrow registers sit in the low byte; the clear register reads zero.
            case (rd_idx)
                IDX_MASK:     nxt_rdata = {24'h0, mask_ff};
                IDX_CFG:      nxt_rdata = {24'h0, deb_sel_ff, 1'b0, thr_ff};   // R7
                IDX_STAT:     nxt_rdata = {24'h0, 1'b0, level_ff, held_ff};    // R13
                IDX_EVT_STAT: nxt_rdata = {29'h0, evt_stat_ff};
                IDX_EVT_EN:   nxt_rdata = {29'h0, evt_en_ff};
                default:      nxt_rdata = 32'h0;
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
    end

    // Bus channel registers.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            aw_ff     <= 1'b0;
            awaddr_ff <= '0;
            w_ff      <= 1'b0;
            wdata_ff  <= 32'h0;
            wstrb0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
            rvalid_ff <= 1'b0;
            rresp_ff  <= RESP_OKAY;
            rdata_ff  <= 32'h0;
        end else begin
            aw_ff     <= nxt_aw;
            awaddr_ff <= nxt_awaddr;
            w_ff      <= nxt_w;
            wdata_ff  <= nxt_wdata;
            wstrb0_ff <= nxt_wstrb0;
            bvalid_ff <= nxt_bvalid;
            bresp_ff  <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rresp_ff  <= nxt_rresp;
            rdata_ff  <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Software registers, group gating and event flags.
    // The clear command is a one-cycle pulse and is never stored, so it always reads 0.
    assign clr_cmd = wr_en && (wr_idx == IDX_CFG) && wdata_ff[CLR_BIT];   // R7
    assign irq     = |(evt_stat_ff & evt_en_ff);
    assign reset_cause_int   = grp_ff[3];
    assign power_monitor_int = grp_ff[2];
    assign power_source_int  = grp_ff[1];
    assign button_int        = grp_ff[0];

    // Next values of configuration, masks and events.
    always_comb begin
        nxt_mask     = mask_ff;
        nxt_deb_sel  = deb_sel_ff;
        nxt_thr      = thr_ff;
        nxt_evt_en   = evt_en_ff;
        nxt_evt_stat = evt_stat_ff;
        if (wr_en && (wr_idx == IDX_MASK)) begin
            nxt_mask = wdata_ff[7:0] & MASK_WR_BITS;   // R5
        end
        if (wr_en && (wr_idx == IDX_CFG)) begin
            nxt_deb_sel = wdata_ff[DEB_SEL_BIT];   // R6
            nxt_thr     = wdata_ff[THR_W-1:0];     // R8
        end
        if (wr_en && (wr_idx == IDX_EVT_EN)) begin
            nxt_evt_en = wdata_ff[EVT_W-1:0];
        end
        if (wr_en && (wr_idx == IDX_EVT_CLR)) begin
            nxt_evt_stat = nxt_evt_stat & ~wdata_ff[EVT_W-1:0];
        end
        // A new event in the clearing cycle survives the clear.
        nxt_evt_stat = nxt_evt_stat | evt_set;
        nxt_grp[3] = reset_cause_req   && !mask_ff[RESET_CAUSE_BIT];   // R1
        nxt_grp[2] = power_monitor_req && !mask_ff[POWER_MON_BIT];     // R2
        nxt_grp[1] = power_source_req  && !mask_ff[POWER_SRC_BIT];     // R3
        nxt_grp[0] = button_req        && !mask_ff[BUTTON_BIT];        // R4
    end

    // Configuration registers.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mask_ff     <= MASK_RESET;               // R5
            deb_sel_ff  <= CFG_RESET[DEB_SEL_BIT];   // R9
            thr_ff      <= CFG_RESET[THR_W-1:0];     // R9
            evt_en_ff   <= '0;
            evt_stat_ff <= '0;
            grp_ff      <= 4'h0;
        end else begin
            mask_ff     <= nxt_mask;
            deb_sel_ff  <= nxt_deb_sel;
            thr_ff      <= nxt_thr;
            evt_en_ff   <= nxt_evt_en;
            evt_stat_ff <= nxt_evt_stat;
            grp_ff      <= nxt_grp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Button path. The level starts at 0 like the rest of the status register, so the
    // timer stays idle until a released level has been seen once after reset.
    assign held = armed_ff && !level_ff;

    // Next values of debounce, hold timer and emergency request.
    always_comb begin
        nxt_level   = level_ff;
        nxt_deb_cnt = 32'h0;
        nxt_sec_cnt = sec_cnt_ff;
        nxt_held    = held_ff;
        nxt_fired   = fired_ff;
        nxt_emerg   = 1'b0;
        evt_set     = '0;
        if (deb_sel_ff) begin
            nxt_level = btn_s2_ff;   // R6
        end else if (btn_s2_ff != level_ff) begin
            // The new level must stand for the whole debounce time to be taken.
            if (deb_cnt_ff >= DEB_CYCLES - 32'h1) begin
                nxt_level = btn_s2_ff;   // R6
            end else begin
                nxt_deb_cnt = deb_cnt_ff + 32'h1;
            end
        end
        nxt_armed = armed_ff || level_ff;
        evt_set[EVT_PRESS]   = armed_ff && level_ff && !nxt_level;
        evt_set[EVT_RELEASE] = armed_ff && !level_ff && nxt_level;
        if (!held || clr_cmd) begin
            nxt_sec_cnt = 32'h0;   // R14
            nxt_held    = 6'h0;    // R7
        end else if (sec_cnt_ff >= SEC_CYCLES - 32'h1) begin
            nxt_sec_cnt = 32'h0;
            if (held_ff != HELD_MAX) begin
                nxt_held = held_ff + 6'h1;   // R11 R14
            end
        end else begin
            nxt_sec_cnt = sec_cnt_ff + 32'h1;
        end
        // Readings 0 and 1 are reported as they are; software treats them as disabled.
        if (!held) begin
            nxt_fired = 1'b0;   // R15
        end else if (!fired_ff && (held_ff == thr_ff)) begin
            nxt_fired = 1'b1;   // R8 R15
            nxt_emerg = 1'b1;   // R15
            evt_set[EVT_EMERGENCY] = 1'b1;
        end
    end

    // Button registers; the pin passes two flip-flops before anything reads it.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            btn_s1_ff  <= 1'b1;
            btn_s2_ff  <= 1'b1;
            deb_cnt_ff <= 32'h0;
            level_ff   <= STAT_RESET[6];   // R10 R13
            armed_ff   <= 1'b0;
            sec_cnt_ff <= 32'h0;
            held_ff    <= STAT_RESET[5:0];   // R12 R13
            fired_ff   <= 1'b0;
            emerg_ff   <= 1'b0;
        end else begin
            btn_s1_ff  <= button_pin_n;
            btn_s2_ff  <= btn_s1_ff;
            deb_cnt_ff <= nxt_deb_cnt;
            level_ff   <= nxt_level;   // R10
            armed_ff   <= nxt_armed;
            sec_cnt_ff <= nxt_sec_cnt;
            held_ff    <= nxt_held;
            fired_ff   <= nxt_fired;
            emerg_ff   <= nxt_emerg;
        end
    end

    assign emergency_reset = emerg_ff;
endmodule
`default_nettype wire

// *** test/pbt_top_assertions.sv ***
// Concurrent checks on the ports of the power button timer block.
`default_nettype none
module pbt_top_assertions (
    // Clock and reset.
    input wire logic        core_clk,
    input wire logic        rstn,
    // Register bus.
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Group requests, masked outputs and emergency pulse.
    input wire logic        reset_cause_req,
    input wire logic        power_monitor_req,
    input wire logic        power_source_req,
    input wire logic        button_req,
    input wire logic        reset_cause_int,
    input wire logic        power_monitor_int,
    input wire logic        power_source_int,
    input wire logic        button_int,
    input wire logic        emergency_reset
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////////
    // A group output may only follow its own request; a mask never creates one.
    rc_int_cause_a: assert property (reset_cause_int |-> $past(reset_cause_req))
        else $error("reset cause output without request");
    pm_int_cause_a: assert property (power_monitor_int |-> $past(power_monitor_req))
        else $error("power monitor output without request");
    ps_int_cause_a: assert property (power_source_int |-> $past(power_source_req))
        else $error("power source output without request");
    btn_int_cause_a: assert property (button_int |-> $past(button_req))
        else $error("button group output without request");
    // The emergency request is a single-cycle pulse.
    emerg_pulse_a: assert property (emergency_reset |=> !emergency_reset)
        else $error("emergency pulse longer than one cycle");
    // Bus answers hold until taken, and the slave refuses while busy.
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped or changed");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
endmodule
bind pbt_top pbt_top_assertions pbt_top_assertions_inst (.*);
`default_nettype wire

// *** test/pbt_button_model.sv ***
// Behavioural push button with contact chatter after each change.
`default_nettype none
module pbt_button_model (
    // Clock and command.
    input  wire logic       core_clk,
    input  wire logic       press,
    input  wire logic [3:0] chatter,
    // Contact, pulled up, low while pressed.
    output logic            button_pin_n
);
    logic       last = 1'b0;
    logic [3:0] left = 4'h0;
    initial button_pin_n = 1'b1;
    // Contacts bounce for a few cycles before settling, so debounce is exercised.
    always @(posedge core_clk) begin
        if (press != last) begin
            last <= press;
            left <= chatter;
        end
        if (left != 4'h0) begin
            left <= left - 4'h1;
            button_pin_n <= ~button_pin_n;
        end else begin
            button_pin_n <= ~last;
        end
    end
endmodule
`default_nettype wire

// *** test/pbt_top_tb.sv ***
// Self-checking bench for the power button timer block.
`default_nettype none
module pbt_top_tb import pbt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] A_MASK = 8'(IDX_MASK * 4);
    localparam logic [7:0] A_CFG  = 8'(IDX_CFG * 4);
    localparam logic [7:0] A_STAT = 8'(IDX_STAT * 4);
    localparam logic [7:0] A_EV   = 8'(IDX_EVT_STAT * 4);
    localparam logic [7:0] A_CLR  = 8'(IDX_EVT_CLR * 4);
    localparam logic [7:0] A_EN   = 8'(IDX_EVT_EN * 4);
    logic core_clk, rstn = 1'b0, press = 1'b0, button_pin_n, emergency_reset, irq;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf, chatter = 4'h0, grp_int;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic reset_cause_req = 1'b0, power_monitor_req = 1'b0;
    logic power_source_req = 1'b0, button_req = 1'b0;
    logic reset_cause_int, power_monitor_int, power_source_int, button_int;
    int   err_count = 0, n_tests = 0, pulses = 0;
    assign grp_int = {reset_cause_int, power_monitor_int, power_source_int, button_int};
    pbt_top #(.DEB_CYCLES(8), .SEC_CYCLES(20)) pbt_top_inst (.*);
    pbt_button_model pbt_button_model_inst (.core_clk(core_clk), .press(press),
        .chatter(chatter), .button_pin_n(button_pin_n));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, pulse counter and watchdog; the watchdog bound is several runs long.
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (emergency_reset === 1'b1) pulses++;
    initial begin
        repeat (10000) @(posedge core_clk);
        err_count++;
        wrap_up();
    end
    task automatic wrap_up();
        $display("errors %0d of %0d checks", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Bus tasks; the ready for each answer is raised only after it shows, so
    // every answer is stalled one cycle and must hold.
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) break;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) s_axi_bready <= 1'b1;
        end
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) break;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) s_axi_rready <= 1'b1;
        end
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, {24'h0, e});
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_reset();
        rd(A_STAT, STAT_RESET, RESP_OKAY);
        rd(A_MASK, 8'ha5, RESP_OKAY);
        rd(A_CFG, 8'h1f, RESP_OKAY);
        rd(8'hfc, 8'h00, RESP_SLVERR);
        wr(8'hfc, 8'h55, RESP_SLVERR);
        wr(A_STAT, 8'hff, RESP_OKAY);
        rd(A_STAT, 8'h40, RESP_OKAY);
        // A write without lane 0 must leave the register alone.
        s_axi_wstrb <= 4'h0;
        wr(A_MASK, 8'h00, RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rd(A_MASK, 8'ha5, RESP_OKAY);
    endtask
    task automatic t_rerst();
        wr(A_CFG, 8'h85, RESP_OKAY);
        rstn <= 1'b0;
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        // Status first, before the released level has passed debounce.
        rd(A_STAT, STAT_RESET, RESP_OKAY);
        rd(A_MASK, 8'ha5, RESP_OKAY);
        rd(A_CFG, 8'h1f, RESP_OKAY);
        chk({28'h0, grp_int}, 32'h0);
    endtask
    task automatic t_mask();
        logic [7:0] mb [4];
        mb = '{8'h80, 8'h20, 8'h04, 8'h01};
        reset_cause_req <= 1'b1;
        power_monitor_req <= 1'b1;
        power_source_req <= 1'b1;
        button_req <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(A_MASK, 8'ha5 & ~mb[i], RESP_OKAY);
            repeat (2) @(posedge core_clk);
            chk({28'h0, grp_int}, {28'h0, 4'h8 >> i});
        end
        wr(A_MASK, 8'hff, RESP_OKAY);
        rd(A_MASK, 8'ha5, RESP_OKAY);
        wr(A_MASK, 8'h00, RESP_OKAY);
        repeat (2) @(posedge core_clk);
        chk({28'h0, grp_int}, 32'hf);
    endtask
    task automatic t_hold();
        int c;
        c = 0;
        wr(A_CFG, 8'h03, RESP_OKAY);
        wr(A_EN, 8'h07, RESP_OKAY);
        chatter <= 4'h3;
        press <= 1'b1;
        while (emergency_reset !== 1'b1 && c < 200) begin
            @(posedge core_clk);
            c++;
        end
        chk(32'(c >= 50 && c <= 90), 32'h1);
        rd(A_STAT, 8'h03, RESP_OKAY);
        repeat (1300) @(posedge core_clk);
        rd(A_STAT, 8'h3f, RESP_OKAY);
        chk(32'(pulses), 32'h1);
        chk({31'h0, irq}, 32'h1);
        press <= 1'b0;
        repeat (30) @(posedge core_clk);
        rd(A_STAT, 8'h40, RESP_OKAY);
        rd(A_EV, 8'h07, RESP_OKAY);
        wr(A_CLR, 8'h07, RESP_OKAY);
        rd(A_EV, 8'h00, RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
    endtask
    task automatic t_clear();
        wr(A_CFG, 8'h3f, RESP_OKAY);
        chatter <= 4'h0;
        press <= 1'b1;
        repeat (55) @(posedge core_clk);
        rd(A_STAT, 8'h02, RESP_OKAY);
        wr(A_CFG, 8'h7f, RESP_OKAY);
        rd(A_STAT, 8'h00, RESP_OKAY);
        rd(A_CFG, 8'h3f, RESP_OKAY);
        press <= 1'b0;
        repeat (20) @(posedge core_clk);
    endtask
    task automatic glitch();
        press <= 1'b1;
        repeat (5) @(posedge core_clk);
        press <= 1'b0;
        repeat (20) @(posedge core_clk);
    endtask
    task automatic t_deb();
        wr(A_EN, 8'h00, RESP_OKAY);
        wr(A_CLR, 8'h07, RESP_OKAY);
        glitch();
        rd(A_EV, 8'h00, RESP_OKAY);
        wr(A_CFG, 8'hbf, RESP_OKAY);
        glitch();
        rd(A_EV, 8'h03, RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        wr(A_EN, 8'h01, RESP_OKAY);
        @(posedge core_clk);
        chk({31'h0, irq}, 32'h1);
        wr(A_CLR, 8'h03, RESP_OKAY);
        @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        t_reset();
        t_mask();
        t_rerst();
        t_hold();
        t_clear();
        t_deb();
        wrap_up();
    end
endmodule
`default_nettype wire
